// ===== hdl/wdt_top.sv
// module: wake-up down-timer with register port, interrupt and wake control
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
  input  wire logic   CLK,
  input  wire logic   SYS_RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic   REG_WR,
  input  wire logic   REG_RD,
  output logic [7:0]  REG_RDATA,
  input  wire logic   OSC_CLK_IN,
  input  wire logic   FIELD_WINDOW_DONE,
  input  wire logic   CARD_SENSE,
  output logic        IRQ,
  output logic        TRIM_START,
  output logic        FIELD_ON,
  output logic        FIELD_WINDOW_START,
  output logic        WAKE_REQ,
  output logic        POWER_DOWN_REQ
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // oscillator input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic osc_rise;

  // the oscillator runs far below CLK, so a sampled edge is safe to count
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= OSC_CLK_IN;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q & ~osc_s3_q;

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  logic wr_ctrl, wr_rel_h, wr_rel_l, wr_stat, wr_mask;

  assign wr_ctrl  = REG_WR && (REG_ADDR == WDT_CTRL_ADDR);
  assign wr_rel_h = REG_WR && (REG_ADDR == WDT_RELOAD_H_ADDR);
  assign wr_rel_l = REG_WR && (REG_ADDR == WDT_RELOAD_L_ADDR);
  assign wr_stat  = REG_WR && (REG_ADDR == WDT_IRQ_STAT_ADDR);
  assign wr_mask  = REG_WR && (REG_ADDR == WDT_IRQ_MASK_ADDR);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  wdt_ctrl_type ctrl_q, ctrl_d;
  logic [7:0]   rel_h_q, rel_h_d;
  logic [7:0]   rel_l_q, rel_l_d;
  logic [15:0]  reload_value;

  always_comb begin
    ctrl_d  = ctrl_q;
    rel_h_d = rel_h_q;
    rel_l_d = rel_l_q;
    if (wr_ctrl) begin
      ctrl_d.trim_en   = REG_WDATA[WDT_TRIM_BIT];
      ctrl_d.detect_en = REG_WDATA[WDT_DETECT_BIT];
      ctrl_d.reload_en = REG_WDATA[WDT_RELOAD_BIT];
      ctrl_d.resume_en = REG_WDATA[WDT_RESUME_BIT];
      ctrl_d.tick_sel  = wdt_tick_type'(REG_WDATA[WDT_TICK_MSB:WDT_TICK_LSB]);
    end
    // reload bytes only feed the counter at a start event or at an underflow with reload or detect set
    if (wr_rel_h) begin
      rel_h_d = REG_WDATA;
    end
    if (wr_rel_l) begin
      rel_l_d = REG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q  <= '0;
      rel_h_q <= WDT_BYTE_RESET;
      rel_l_q <= WDT_BYTE_RESET;
    end else begin
      ctrl_q  <= ctrl_d;
      rel_h_q <= rel_h_d;
      rel_l_q <= rel_l_d;
    end
  end

  assign reload_value = {rel_h_q, rel_l_q};

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  logic        run_q, run_d;
  logic [15:0] count_q, count_d;
  logic        under_q, under_d;
  logic        tick;

  wdt_tick_div u_div (
    .clk      (CLK),
    .rst      (SYS_RST),
    .run      (run_q),
    .osc_rise (osc_rise),
    .sel      (ctrl_q.tick_sel),
    .tick     (tick)
  );

  always_comb begin
    run_d   = run_q;
    count_d = count_q;
    under_d = 1'b0;
    if (run_q && tick) begin
      if (count_q == WDT_WORD_RESET) begin
        under_d = 1'b1;
        // detection mode always restarts so periods follow with no gap
        if (ctrl_q.reload_en || ctrl_q.detect_en) begin
          count_d = reload_value;
        end else begin
          run_d = 1'b0;
        end
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
    // a strobed control write overrides the countdown in the same cycle
    if (wr_ctrl && REG_WDATA[WDT_STROBE_BIT]) begin
      run_d = REG_WDATA[WDT_ACTIVE_BIT];
      if (REG_WDATA[WDT_ACTIVE_BIT]) begin
        count_d = reload_value;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run_q   <= 1'b0;
      count_q <= WDT_WORD_RESET;
      under_q <= 1'b0;
    end else begin
      run_q   <= run_d;
      count_q <= count_d;
      under_q <= under_d;
    end
  end

  // ----------------------------------------------------------------
  // card detection
  // ----------------------------------------------------------------
  wdt_result_type det_res;
  logic           field_on;
  logic           win_start;

  wdt_card_seq u_seq (
    .clk          (CLK),
    .rst          (SYS_RST),
    .start        (under_q && ctrl_q.detect_en),
    .window_done  (FIELD_WINDOW_DONE),
    .card_sense   (CARD_SENSE),
    .field_on     (field_on),
    .window_start (win_start),
    .result       (det_res)
  );

  // ----------------------------------------------------------------
  // power and procedure requests
  // ----------------------------------------------------------------
  logic trim_d, wake_d, pdown_d;

  always_comb begin
    trim_d  = under_q && ctrl_q.trim_en;
    // a found card always raises a one-cycle wake request, whether or not resume is set
    wake_d  = (under_q && ctrl_q.resume_en) || det_res.found;
    // software is expected to set resume only when it wants this return
    pdown_d = det_res.none && ctrl_q.resume_en;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TRIM_START         <= 1'b0;
      WAKE_REQ           <= 1'b0;
      POWER_DOWN_REQ     <= 1'b0;
      FIELD_ON           <= 1'b0;
      FIELD_WINDOW_START <= 1'b0;
    end else begin
      TRIM_START         <= trim_d;
      WAKE_REQ           <= wake_d;
      POWER_DOWN_REQ     <= pdown_d;
      FIELD_ON           <= field_on;
      FIELD_WINDOW_START <= win_start;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [WDT_EV_NUM-1:0] stat_q, stat_d;
  logic [WDT_EV_NUM-1:0] mask_q, mask_d;
  logic [WDT_EV_NUM-1:0] ev;
  logic                  irq_d;

  assign ev[WDT_EV_UNDERFLOW] = under_q;
  assign ev[WDT_EV_CARD]      = det_res.found;
  assign ev[WDT_EV_NO_CARD]   = det_res.none;

  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_stat) begin
      stat_d = stat_q & ~REG_WDATA[WDT_EV_NUM-1:0];
    end
    // setting after the clear keeps an event that meets a clear
    stat_d = stat_d | ev;
    if (wr_mask) begin
      mask_d = REG_WDATA[WDT_EV_NUM-1:0];
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_q <= '0;
      mask_q <= '0;
      IRQ    <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      IRQ    <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        WDT_CTRL_ADDR: begin
          // the strobe bit is write-only and reads as zero
          rdata_d = {run_q, 1'b0, ctrl_q.trim_en, ctrl_q.detect_en,
                     ctrl_q.reload_en, ctrl_q.resume_en, ctrl_q.tick_sel};
        end
        WDT_RELOAD_H_ADDR: rdata_d = rel_h_q;
        WDT_RELOAD_L_ADDR: rdata_d = rel_l_q;
        WDT_COUNT_H_ADDR:  rdata_d = count_q[15:8];
        WDT_COUNT_L_ADDR:  rdata_d = count_q[7:0];
        WDT_IRQ_STAT_ADDR: rdata_d = {5'h00, stat_q};
        WDT_IRQ_MASK_ADDR: rdata_d = {5'h00, mask_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end
endmodule // wdt_top
`default_nettype wire

// ===== hdl/wdt_pkg.sv
// package: register map, field layout and shared types of the wake-up timer
package wdt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] WDT_CTRL_ADDR     = 8'h23;
  localparam logic [7:0] WDT_RELOAD_H_ADDR = 8'h24;
  localparam logic [7:0] WDT_RELOAD_L_ADDR = 8'h25;
  localparam logic [7:0] WDT_COUNT_H_ADDR  = 8'h26;
  localparam logic [7:0] WDT_COUNT_L_ADDR  = 8'h27;
  localparam logic [7:0] WDT_IRQ_STAT_ADDR = 8'h30;
  localparam logic [7:0] WDT_IRQ_MASK_ADDR = 8'h31;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int WDT_ACTIVE_BIT  = 7;
  localparam int WDT_STROBE_BIT  = 6;
  localparam int WDT_TRIM_BIT    = 5;
  localparam int WDT_DETECT_BIT  = 4;
  localparam int WDT_RELOAD_BIT  = 3;
  localparam int WDT_RESUME_BIT  = 2;
  localparam int WDT_TICK_MSB    = 1;
  localparam int WDT_TICK_LSB    = 0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int WDT_EV_UNDERFLOW = 0;
  localparam int WDT_EV_CARD      = 1;
  localparam int WDT_EV_NO_CARD   = 2;
  localparam int WDT_EV_NUM       = 3;

  // ----------------------------------------------------------------
  // reset values and divider counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  WDT_BYTE_RESET  = 8'h00;
  localparam logic [15:0] WDT_WORD_RESET  = 16'h0000;
  localparam logic [4:0]  WDT_DIV8_LAST   = 5'h07;
  localparam logic [4:0]  WDT_DIV16_LAST  = 5'h0f;
  localparam logic [4:0]  WDT_DIV32_LAST  = 5'h1f;

  typedef enum logic [1:0] {
    WDT_TICK_DIV1  = 2'h0,
    WDT_TICK_DIV8  = 2'h1,
    WDT_TICK_DIV16 = 2'h2,
    WDT_TICK_DIV32 = 2'h3
  } wdt_tick_type;

  typedef struct packed {
    logic         trim_en;
    logic         detect_en;
    logic         reload_en;
    logic         resume_en;
    wdt_tick_type tick_sel;
  } wdt_ctrl_type;

  typedef struct packed {
    logic found;
    logic none;
  } wdt_result_type;

endpackage : wdt_pkg

// ===== hdl/wdt_tick_div.sv
// module: oscillator-edge prescaler producing the countdown tick
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_div (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               run,
  input  wire logic               osc_rise,
  input  wire wdt_pkg::wdt_tick_type sel,
  output logic                    tick
);
  import wdt_pkg::*;

  logic [4:0] pre_q, pre_d;
  logic [4:0] last;
  logic       tick_d;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    unique case (sel)
      WDT_TICK_DIV1:  last = 5'h00;
      WDT_TICK_DIV8:  last = WDT_DIV8_LAST;
      WDT_TICK_DIV16: last = WDT_DIV16_LAST;
      WDT_TICK_DIV32: last = WDT_DIV32_LAST;
    endcase
    pre_d  = pre_q;
    tick_d = 1'b0;
    // held at zero while idle so a start from idle sees a full first period
    if (!run) begin
      pre_d = 5'h00;
    end else if (osc_rise) begin
      if (pre_q >= last) begin
        pre_d  = 5'h00;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 5'h00;
      tick  <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick  <= tick_d;
    end
  end
endmodule // wdt_tick_div
`default_nettype wire

// ===== hdl/wdt_card_seq.sv
// module: card detection sequence, field window timed by timer 3
`timescale 1ns/1ps
`default_nettype none
module wdt_card_seq (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic                    window_done,
  input  wire logic                    card_sense,
  output logic                         field_on,
  output logic                         window_start,
  output wdt_pkg::wdt_result_type      result
);
  import wdt_pkg::*;

  typedef enum logic [1:0] {WDT_SEQ_IDLE, WDT_SEQ_FIELD, WDT_SEQ_DECIDE} wdt_seq_type;

  wdt_seq_type    st_q, st_d;
  logic           field_d, win_d;
  wdt_result_type res_d;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    field_d = field_on;
    win_d   = 1'b0;
    res_d   = '0;
    unique case (st_q)
      WDT_SEQ_IDLE: begin
        if (start) begin
          st_d    = WDT_SEQ_FIELD;
          field_d = 1'b1;
          win_d   = 1'b1;
        end
      end
      WDT_SEQ_FIELD: begin
        if (window_done) begin
          st_d = WDT_SEQ_DECIDE;
        end
      end
      WDT_SEQ_DECIDE: begin
        st_d      = WDT_SEQ_IDLE;
        field_d   = 1'b0;
        res_d.found = card_sense;
        res_d.none  = !card_sense;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q         <= WDT_SEQ_IDLE;
      field_on     <= 1'b0;
      window_start <= 1'b0;
      result       <= '0;
    end else begin
      st_q         <= st_d;
      field_on     <= field_d;
      window_start <= win_d;
      result       <= res_d;
    end
  end
endmodule // wdt_card_seq
`default_nettype wire

// ===== tb/wdt_top_sva.sv
// checker: port-level assertions of the wake-up timer
`timescale 1ns/1ps
`default_nettype none
module wdt_top_sva (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       OSC_CLK_IN,
  input wire logic       FIELD_WINDOW_DONE,
  input wire logic       CARD_SENSE,
  input wire logic       IRQ,
  input wire logic       TRIM_START,
  input wire logic       FIELD_ON,
  input wire logic       FIELD_WINDOW_START,
  input wire logic       WAKE_REQ,
  input wire logic       POWER_DOWN_REQ
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_rdata_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_reads_zero: assert property (
    REG_RD && (REG_ADDR < 8'h23 || REG_ADDR > 8'h31) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_trim_one_cycle: assert property (TRIM_START |=> !TRIM_START)
    else $error("trim start longer than one cycle");
  a_field_begin: assert property ($rose(FIELD_ON) |-> FIELD_WINDOW_START)
    else $error("field on without window start");
  a_window_pulse: assert property (
    FIELD_WINDOW_START |-> FIELD_ON ##1 (FIELD_ON && !FIELD_WINDOW_START))
    else $error("window start malformed");
  a_card_wakes: assert property (
    (FIELD_ON && FIELD_WINDOW_DONE) ##1 CARD_SENSE |=> ##1 (WAKE_REQ && !POWER_DOWN_REQ))
    else $error("card found without wake");
  a_nocard_no_wake: assert property (
    (FIELD_ON && FIELD_WINDOW_DONE) ##1 !CARD_SENSE |=> ##1 (!WAKE_REQ && !FIELD_ON))
    else $error("no card handled wrongly");
  a_field_end_cause: assert property ($fell(FIELD_ON) |-> $past(FIELD_WINDOW_DONE, 3))
    else $error("field dropped without window end");
  a_down_alone: assert property (POWER_DOWN_REQ |-> $fell(FIELD_ON) && !WAKE_REQ)
    else $error("power down at wrong time");

  c_window: cover property (FIELD_WINDOW_START);
  c_card_wake: cover property (WAKE_REQ && $fell(FIELD_ON));
  c_power_down: cover property (POWER_DOWN_REQ);
  c_trim: cover property (TRIM_START);
endmodule // wdt_top_sva

bind wdt_top wdt_top_sva i_wdt_top_sva (.CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR,
  .REG_RD, .REG_RDATA, .OSC_CLK_IN, .FIELD_WINDOW_DONE, .CARD_SENSE, .IRQ, .TRIM_START,
  .FIELD_ON, .FIELD_WINDOW_START, .WAKE_REQ, .POWER_DOWN_REQ);
`default_nettype wire

// ===== tb/tb.sv
// testbench: register, timer, interrupt and card detection scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic       OSC_CLK_IN = 1'b0;
  logic       FIELD_WINDOW_DONE = 1'b0;
  logic       CARD_SENSE = 1'b0;
  logic [7:0] REG_RDATA;
  logic       IRQ, TRIM_START, FIELD_ON, FIELD_WINDOW_START, WAKE_REQ, POWER_DOWN_REQ;
  int         miscompares = 0;
  int         compares = 0;
  int         edges = 0, trims = 0, wakes = 0, downs = 0, e0, n, x;
  logic       osc_en = 1'b0;
  logic       card_mode = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  logic [3:0] win_q = 4'h0;
  logic [7:0] rv;
  logic [15:0] rl;
  logic [7:0] addrs [8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30, 8'h31, 8'h40};

  always #5 CLK = ~CLK;

  wdt_top i_wdt_top (.CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .OSC_CLK_IN, .FIELD_WINDOW_DONE, .CARD_SENSE, .IRQ, .TRIM_START, .FIELD_ON,
    .FIELD_WINDOW_START, .WAKE_REQ, .POWER_DOWN_REQ);

  // ------------------------------------------------------------
  // oscillator, timer-3 stand-in and pulse counters
  // ------------------------------------------------------------
  // card sense is noise except around the sampling cycle, so a stale level cannot pass
  always @(posedge CLK) begin
    if (osc_en) osc_cnt <= osc_cnt + 3'h1;
    OSC_CLK_IN <= osc_cnt[2];
    if (osc_cnt[2] && !OSC_CLK_IN) edges <= edges + 1;
    win_q <= {win_q[2:0], FIELD_WINDOW_START};
    FIELD_WINDOW_DONE <= win_q[3];
    CARD_SENSE <= (win_q[3] | FIELD_WINDOW_DONE) ? card_mode : 1'($urandom);
    trims <= trims + int'(TRIM_START);
    wakes <= wakes + int'(WAKE_REQ);
    downs <= downs + int'(POWER_DOWN_REQ);
  end

  function automatic int exp_ticks(input int s, input int r);
    return (r + 1) * (s == 0 ? 1 : 4 << s);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, e);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge CLK);
    #1;
    chk({7'h00, IRQ}, {7'h00, e});
  endtask

  // a cleared status drops the level on the same edge that takes the write
  task automatic wait_irq();
    int i;
    repeat (2) @(posedge CLK);
    #1;
    for (i = 0; i < 5000 && IRQ !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (IRQ !== 1'b1) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, IRQ, 1'b1);
      final_report();
    end
  endtask

  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(39579));
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'b0;
    foreach (addrs[i]) rc(addrs[i], 8'h00);
    wr(8'h40, 8'hff);
    rc(8'h40, 8'h00);
    $display("test reset done");
    rl = 16'($urandom_range(16'hfffe, 16'h0100));
    wr(8'h24, rl[15:8]);
    wr(8'h25, rl[7:0]);
    wr(8'h23, 8'h80);
    rc(8'h23, 8'h00);
    rc(8'h24, rl[15:8]);
    wr(8'h23, 8'hc0);
    rc(8'h23, 8'h80);
    rc(8'h26, rl[15:8]);
    rc(8'h27, rl[7:0]);
    wr(8'h25, ~rl[7:0]);
    rc(8'h27, rl[7:0]);
    wr(8'h23, 8'h08);
    rc(8'h23, 8'h88);
    wr(8'h23, 8'hc0);
    rc(8'h27, ~rl[7:0]);
    wr(8'h23, 8'h40);
    rc(8'h23, 8'h00);
    $display("test strobe done");
    osc_en <= 1'b1;
    wr(8'h31, 8'h01);
    wr(8'h24, 8'h00);
    for (n = 0; n < 4; n++) begin
      rv = 8'($urandom_range(7, 1));
      wr(8'h25, rv);
      wr(8'h30, 8'h07);
      rc(8'h30, 8'h00);
      wr(8'h23, 8'hc0 | 8'(n));
      e0 = edges;
      wait_irq();
      x = exp_ticks(n, int'(rv));
      chk_in(edges - e0, x - 1, x + 1);
      rc(8'h23, 8'(n));
      rc(8'h27, 8'h00);
    end
    wr(8'h31, 8'h00);
    irq_is(1'b0);
    wr(8'h31, 8'h01);
    irq_is(1'b1);
    wr(8'h30, 8'h01);
    irq_is(1'b0);
    $display("test halt done");
    wr(8'h25, 8'h02);
    e0 = trims;
    x = wakes;
    wr(8'h23, 8'hec);
    repeat (3) begin
      wait_irq();
      wr(8'h30, 8'h01);
    end
    rc(8'h23, 8'hac);
    chk(8'(trims - e0), 8'h03);
    chk(8'(wakes - x), 8'h03);
    wr(8'h23, 8'h40);
    rc(8'h23, 8'h00);
    $display("test reload done");
    wr(8'h31, 8'h06);
    for (n = 0; n < 2; n++) begin
      card_mode <= (n == 0);
      wr(8'h30, 8'h07);
      e0 = downs;
      wr(8'h23, 8'hd4);
      wait_irq();
      repeat (4) @(posedge CLK);
      rc(8'h30, (n == 0) ? 8'h03 : 8'h05);
      rc(8'h23, 8'h94);
      chk({7'h00, downs != e0}, {7'h00, n == 1});
      wr(8'h23, 8'h40);
    end
    $display("test detect done");
    final_report();
  end
endmodule // tb
`default_nettype wire
